// ==== cycle_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

module cycle_timer #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  // Control
  input  wire logic         load_i,
  input  wire logic [W-1:0] count_i,
  output logic              done_o
);

  logic [W-1:0] count;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      count <= '0;
    end else if (load_i) begin
      count <= count_i;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign done_o = (count == '0) && !load_i;

endmodule // cycle_timer
`default_nettype wire

// ==== flash_dev_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Behavioural flash device on the parallel bus
// ----------------------------------------------------------------
module flash_dev_model #(
  parameter int          ERASE_NS = 3000,
  parameter int          RECOV_NS = 400,
  parameter int          CLEAR_NS = 500,
  parameter int          ACC_NS   = 90,
  parameter logic [15:0] MFR_CODE = 16'h00a7, // Arbitrary value.
  parameter logic [15:0] DEV_CODE = 16'h3c5e  // Arbitrary value.
) (
  // Bus pins
  input  wire logic        chip_select_n_i,
  input  wire logic        output_enable_n_i,
  input  wire logic        write_enable_n_i,
  input  wire logic        hard_clear_n_i,
  input  wire logic [18:0] addr_i,
  input  wire logic [15:0] data_i,
  output logic      [15:0] data_o,
  output logic             ready_busy_n_o,
  // Fault injection
  input  wire logic        fail_i
);
  logic [15:0] mem [1024];
  logic [2:0]  seq;
  logic [6:0]  sa;
  logic        id_mode, busy, fail, tog, recov, rd_ok, all;
  realtime     t_low;
  event        go;
  wire logic wr_act = !chip_select_n_i && !write_enable_n_i && output_enable_n_i
                      && hard_clear_n_i;
  wire logic rd_act = !chip_select_n_i && !output_enable_n_i && write_enable_n_i
                      && hard_clear_n_i;
  wire logic [9:0] ix = {addr_i[18:12], addr_i[2:0]};
  wire logic u1 = addr_i[10:0] == 11'h555;
  wire logic u2 = addr_i[10:0] == 11'h2aa;
  wire logic [7:0] d = data_i[7:0];
  wire logic [15:0] q = busy ? {8'h00, 1'b0, tog, fail, 5'h00}
                      : id_mode ? (addr_i[0] ? DEV_CODE : MFR_CODE)
                      : mem[ix];
  // Data not yet valid or not driven shows the bitwise inverse of the word that would be read, not the word itself.
  assign data_o = (rd_act && rd_ok) ? q : ~q;
  assign ready_busy_n_o = !(busy || recov);
  initial begin
    seq = 3'h0; id_mode = 0; busy = 0; fail = 0; tog = 0; recov = 0; rd_ok = 0;
    all = 0; sa = 7'h00; t_low = 0;
    for (int i = 0; i < 1024; i++) mem[i] = 16'(i * 16'h9e37) ^ 16'h5a5a;
  end
  always @(posedge rd_act) begin
    rd_ok = 0;
    #(ACC_NS) rd_ok = rd_act;
  end
  always @(negedge rd_act) if (busy) tog = !tog;
  always @(negedge wr_act) begin
    if (d == 8'hf0 && (!busy || fail)) begin
      seq = 3'h0; id_mode = 0; busy = 0; fail = 0;
    end else if (!busy) begin
      case (seq)
        3'h0, 3'h3: seq = (u1 && d == 8'haa) ? seq + 3'h1 : 3'h0;
        3'h1, 3'h4: seq = (u2 && d == 8'h55) ? seq + 3'h1 : 3'h0;
        3'h2: begin
          id_mode = u1 && d == 8'h90;
          seq = (u1 && d == 8'h80) ? 3'h3 : 3'h0;
        end
        default: begin
          seq = 3'h0;
          all = u1 && d == 8'h10;
          sa = addr_i[18:12];
          if (all) for (int i = 0; i < 1024; i++) mem[i] = 16'h0000;
          if (all || d == 8'h30) begin
            busy = 1;
            -> go;
          end
        end
      endcase
    end
  end
  always begin : run
    @(go);
    #(ERASE_NS);
    if (fail_i) fail = 1;
    else begin
      for (int i = 0; i < 1024; i++) if (all || i[9:3] == sa) mem[i] = 16'hffff;
      busy = 0;
    end
  end
  always @(negedge hard_clear_n_i) t_low = $realtime;
  always @(posedge hard_clear_n_i) if ($realtime - t_low >= CLEAR_NS) begin
    disable run;
    recov = busy;
    seq = 3'h0; id_mode = 0; busy = 0; fail = 0;
    if (recov) #(RECOV_NS) recov = 0;
  end
endmodule // flash_dev_model

`default_nettype wire

// ==== flash_host.sv ====
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Reads drive chip select and output enable low, write enable high.
// - Command writes drive write enable and chip select low, output enable high.
// - Host should restart operations cut short by a hardware clear; it only sets done and leaves the reissue to software.
// - Host waits the release delay after clear before reading.
// - Erase is six writes: unlock, unlock, setup, unlock, unlock, erase byte.
// - Unlock and setup cycles use the fixed low word addresses.
module flash_host
  import flash_host_pkg::*;
#(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 16
) (
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  // Register port
  input  wire logic [3:0]        reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [31:0]       reg_rdata_o,
  // Flash pins
  output logic                   chip_select_n_o,
  output logic                   output_enable_n_o,
  output logic                   write_enable_n_o,
  output logic                   hard_clear_n_o,
  output logic      [ADDR_W-1:0] flash_addr_o,
  input  wire logic [DATA_W-1:0] flash_data_i,
  output logic      [DATA_W-1:0] flash_data_o,
  output logic                   flash_data_oe_n_o,
  input  wire logic              ready_busy_n_i
);
  import flash_host_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_WRITE  = 3'b001,
    S_GAP    = 3'b011,
    S_READ   = 3'b010,
    S_CLEAR  = 3'b110,
    S_REL    = 3'b111,
    S_POLL   = 3'b101
  } state_e;

  state_e            state;
  logic [2:0]        op;
  logic [2:0]        step;
  logic [ADDR_W-1:0] user_addr;
  logic [DATA_W-1:0] user_data;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] prev_poll;
  logic              prev_valid;
  logic              busy;
  logic              done;
  logic              fail;
  logic              poll_to;
  logic [15:0]       poll_max;
  logic [15:0]       poll_cnt;
  logic [31:0]       rd_word;
  logic              tmr_load;
  logic [7:0]        tmr_count;
  logic              tmr_done;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire cmd_wr   = reg_wr_i && (reg_addr_i == REG_CMD) && !busy;
  wire [2:0] new_op = reg_wdata_i[2:0];
  wire op_valid = (new_op != 3'h0);
  wire [31:0] status_word = {27'h0, poll_to, ready_busy_n_i, fail, done, busy};

  always_comb begin
    unique case (reg_addr_i)
      REG_ADDR:     rd_word = 32'(user_addr);
      REG_WDATA:    rd_word = 32'(user_data);
      REG_STATUS:   rd_word = status_word;
      REG_RDATA:    rd_word = 32'(rdata);
      REG_POLL_MAX: rd_word = {16'h0, poll_max};
      default:      rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h0;
      user_addr   <= '0;
      user_data   <= '0;
      poll_max    <= POLL_MAX_RESET;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_word : 32'h0;
      if (reg_wr_i && reg_addr_i == REG_ADDR) user_addr <= reg_wdata_i[ADDR_W-1:0];
      if (reg_wr_i && reg_addr_i == REG_WDATA) user_data <= reg_wdata_i[DATA_W-1:0];
      if (reg_wr_i && reg_addr_i == REG_POLL_MAX) poll_max <= reg_wdata_i[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Sequence tables
  // ----------------------------------------------------------------
  // Erase and identifier sequences are built from the unlock pair; the
  // last cycle of sector erase carries the user's sector address.
  logic [ADDR_W-1:0] seq_addr;
  logic [DATA_W-1:0] seq_data;
  always_comb begin
    seq_addr = ADDR_UNLOCK1;
    seq_data = CMD_UNLOCK1;
    unique case (step)
      3'd0, 3'd3: begin
        seq_addr = ADDR_UNLOCK1;
        seq_data = CMD_UNLOCK1;
      end
      3'd1, 3'd4: begin
        seq_addr = ADDR_UNLOCK2;
        seq_data = CMD_UNLOCK2;
      end
      3'd2: begin
        seq_addr = ADDR_UNLOCK1;
        seq_data = (op == OP_READ_ID) ? CMD_READ_ID : CMD_ERASE_SET;
      end
      default: begin
        seq_addr = (op == OP_SECT_ERASE) ? user_addr : ADDR_UNLOCK1;
        seq_data = (op == OP_SECT_ERASE) ? CMD_SECT_ERASE : CMD_CHIP_ERASE;
      end
    endcase
    if (op == OP_WRITE) begin
      seq_addr = user_addr;
      seq_data = user_data;
    end else if (op == OP_RESET_CMD) begin
      seq_addr = user_addr;
      seq_data = CMD_RESET;
    end
  end

  logic [2:0] op_last;
  assign op_last = (op == OP_READ_ID) ? 3'd2 :
                   (op == OP_CHIP_ERASE || op == OP_SECT_ERASE) ? 3'd5 : 3'd0;
  wire is_erase  = (op == OP_CHIP_ERASE) || (op == OP_SECT_ERASE);
  wire id_read   = (op == OP_READ_ID);

  // ----------------------------------------------------------------
  // Pulse timer
  // ----------------------------------------------------------------
  cycle_timer #(.W(8)) u_timer (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .load_i    (tmr_load),
    .count_i   (tmr_count),
    .done_o    (tmr_done)
  );

  // Toggle stop is judged between two consecutive status reads.
  wire toggle_same = prev_valid &&
                     (prev_poll[TOGGLE_BIT] == flash_data_i[TOGGLE_BIT]);
  wire poll_ok  = flash_data_i[POLL_BIT] || toggle_same;
  wire poll_bad = flash_data_i[TIMEOUT_BIT] && !toggle_same;

  // ----------------------------------------------------------------
  // Bus sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state             <= S_IDLE;
      op                <= 3'h0;
      step              <= 3'h0;
      busy              <= 1'b0;
      done              <= 1'b0;
      fail              <= 1'b0;
      poll_to           <= 1'b0;
      rdata             <= '0;
      prev_poll         <= '0;
      prev_valid        <= 1'b0;
      poll_cnt          <= 16'h0;
      chip_select_n_o   <= 1'b1;
      output_enable_n_o <= 1'b1;
      write_enable_n_o  <= 1'b1;
      hard_clear_n_o    <= 1'b1;
      flash_addr_o      <= '0;
      flash_data_o      <= '0;
      flash_data_oe_n_o <= 1'b1;
      tmr_load          <= 1'b0;
      tmr_count         <= 8'h0;
    end else begin
      tmr_load <= 1'b0;
      // Data stay driven one cycle past each write pulse, so the latch edge sees them settled.
      if (state != S_WRITE) flash_data_oe_n_o <= 1'b1;
      unique case (state)
        S_IDLE: begin
          if (cmd_wr && op_valid) begin
            op      <= new_op;
            step    <= 3'h0;
            busy    <= 1'b1;
            done    <= 1'b0;
            fail    <= 1'b0;
            poll_to <= 1'b0;
            tmr_load <= 1'b1;
            if (new_op == OP_READ) begin
              // Direct read: the device is in read-array mode.
              state             <= S_READ;
              flash_addr_o      <= user_addr;
              chip_select_n_o   <= 1'b0;
              output_enable_n_o <= 1'b0;
              tmr_count         <= 8'(ACCESS_CYC);
            end else if (new_op == OP_HARD_CLEAR) begin
              state          <= S_CLEAR;
              hard_clear_n_o <= 1'b0;
              tmr_count      <= 8'(CLEAR_CYC);
            end else begin
              state <= S_GAP;
              tmr_count <= 8'h1;
            end
          end
        end
        S_GAP: begin
          // Three idle cycles precede each write; address and data are driven on the same edge as write enable.
          if (tmr_done && op == OP_READ) begin
            // After the identifier unlock the first read is the maker code.
            state             <= S_READ;
            flash_addr_o      <= ADDR_MFR_ID;
            chip_select_n_o   <= 1'b0;
            output_enable_n_o <= 1'b0;
            tmr_load          <= 1'b1;
            tmr_count         <= 8'(ACCESS_CYC);
          end else if (tmr_done) begin
            state             <= S_WRITE;
            flash_addr_o      <= seq_addr;
            flash_data_o      <= seq_data;
            flash_data_oe_n_o <= 1'b0;
            chip_select_n_o   <= 1'b0;
            write_enable_n_o  <= 1'b0;
            output_enable_n_o <= 1'b1;
            tmr_load          <= 1'b1;
            tmr_count         <= 8'(WRITE_CYC);
          end
        end
        S_WRITE: begin
          if (tmr_done) begin
            // Raising both strobes together ends the write pulse.
            write_enable_n_o  <= 1'b1;
            chip_select_n_o   <= 1'b1;
            tmr_load          <= 1'b1;
            tmr_count         <= 8'h1;
            if (step == op_last) begin
              if (is_erase) begin
                state      <= S_POLL;
                prev_valid <= 1'b0;
                poll_cnt   <= 16'h0;
              end else if (id_read) begin
                // Address moves only after the hold cycle of the last write.
                state        <= S_GAP;
                op           <= OP_READ;
              end else begin
                state <= S_IDLE;
                busy  <= 1'b0;
                done  <= 1'b1;
              end
            end else begin
              step  <= step + 3'h1;
              state <= S_GAP;
            end
          end
        end
        S_READ: begin
          if (tmr_done) begin
            rdata             <= flash_data_i;
            chip_select_n_o   <= 1'b1;
            output_enable_n_o <= 1'b1;
            state             <= S_IDLE;
            busy              <= 1'b0;
            done              <= 1'b1;
          end
        end
        S_CLEAR: begin
          if (tmr_done) begin
            hard_clear_n_o <= 1'b1;
            state          <= S_REL;
            tmr_load       <= 1'b1;
            tmr_count      <= 8'(RELEASE_CYC);
          end
        end
        S_REL: begin
          // Wait out the release delay and any busy recovery.
          if (tmr_done && ready_busy_n_i) begin
            // Done tells software that a cut operation may be issued again.
            state <= S_IDLE;
            busy  <= 1'b0;
            done  <= 1'b1;
          end
        end
        S_POLL: begin
          if (output_enable_n_o) begin
            if (tmr_done) begin
              chip_select_n_o   <= 1'b0;
              output_enable_n_o <= 1'b0;
              tmr_load          <= 1'b1;
              tmr_count         <= 8'(ACCESS_CYC);
            end
          end else if (tmr_done) begin
            chip_select_n_o   <= 1'b1;
            output_enable_n_o <= 1'b1;
            prev_poll         <= flash_data_i;
            prev_valid        <= 1'b1;
            rdata             <= flash_data_i;
            poll_cnt          <= poll_cnt + 16'h1;
            tmr_load          <= 1'b1;
            tmr_count         <= 8'h1;
            if (poll_ok) begin
              state <= S_IDLE;
              busy  <= 1'b0;
              done  <= 1'b1;
            end else if (poll_bad || poll_cnt == poll_max) begin
              // A failed erase leaves the device needing a reset command; a poll timeout leaves it still busy.
              state   <= S_IDLE;
              busy    <= 1'b0;
              fail    <= 1'b1;
              poll_to <= (poll_cnt == poll_max);
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_read_strobes: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !output_enable_n_o |-> write_enable_n_o && !chip_select_n_o)
    else $error("Read with write enable low.");
  a_write_strobes: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !write_enable_n_o |-> output_enable_n_o && !chip_select_n_o && !flash_data_oe_n_o)
    else $error("Write with output enable low.");
  a_clear_width: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $fell(hard_clear_n_o) |-> !hard_clear_n_o [*8])
    else $error("Clear pulse too short.");
  a_release_wait: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(hard_clear_n_o) |-> output_enable_n_o [*2])
    else $error("Read too soon after clear.");
  a_unlock_first: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $fell(write_enable_n_o) && step == 3'd0 && is_erase |->
      flash_addr_o == ADDR_UNLOCK1 && flash_data_o == CMD_UNLOCK1)
    else $error("Erase does not open with unlock.");
  a_erase_last: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $fell(write_enable_n_o) && step == 3'd5 && op == OP_SECT_ERASE |->
      flash_data_o == CMD_SECT_ERASE && flash_addr_o == user_addr)
    else $error("Sector erase byte wrong.");
  a_no_contend: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !flash_data_oe_n_o |-> output_enable_n_o)
    else $error("Bus contention on data pins.");
  a_busy_done: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $fell(busy) |-> done || fail)
    else $error("Busy dropped without result.");

endmodule // flash_host
`default_nettype wire

// ==== flash_host_pkg.sv ====
package flash_host_pkg;

  // ----------------------------------------------------------------
  // Host register map
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CMD      = 4'h0;
  localparam logic [3:0] REG_ADDR     = 4'h1;
  localparam logic [3:0] REG_WDATA    = 4'h2;
  localparam logic [3:0] REG_STATUS   = 4'h3;
  localparam logic [3:0] REG_RDATA    = 4'h4;
  localparam logic [3:0] REG_POLL_MAX = 4'h5;

  // ----------------------------------------------------------------
  // Command codes written to REG_CMD
  // ----------------------------------------------------------------
  localparam logic [2:0] OP_READ       = 3'h1;
  localparam logic [2:0] OP_WRITE      = 3'h2;
  localparam logic [2:0] OP_RESET_CMD  = 3'h3;
  localparam logic [2:0] OP_READ_ID    = 3'h4;
  localparam logic [2:0] OP_CHIP_ERASE = 3'h5;
  localparam logic [2:0] OP_SECT_ERASE = 3'h6;
  localparam logic [2:0] OP_HARD_CLEAR = 3'h7;

  // ----------------------------------------------------------------
  // Status register bit positions
  // ----------------------------------------------------------------
  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_FAIL    = 2;
  localparam int ST_RDY_PIN = 3;
  localparam int ST_POLL_TO = 4;

  // ----------------------------------------------------------------
  // Device command bytes and unlock addresses (word mode)
  // ----------------------------------------------------------------
  localparam logic [15:0] CMD_RESET      = 16'h00f0;
  localparam logic [15:0] CMD_UNLOCK1    = 16'h00aa;
  localparam logic [15:0] CMD_UNLOCK2    = 16'h0055;
  localparam logic [15:0] CMD_READ_ID    = 16'h0090;
  localparam logic [15:0] CMD_ERASE_SET  = 16'h0080;
  localparam logic [15:0] CMD_CHIP_ERASE = 16'h0010;
  localparam logic [15:0] CMD_SECT_ERASE = 16'h0030;
  localparam logic [18:0] ADDR_UNLOCK1   = 19'h00555;
  localparam logic [18:0] ADDR_UNLOCK2   = 19'h002aa;
  localparam logic [18:0] ADDR_MFR_ID    = 19'h00000;
  localparam logic [18:0] ADDR_DEV_ID    = 19'h00001;

  // Status bit positions on the low data byte.
  localparam int POLL_BIT    = 7;
  localparam int TOGGLE_BIT  = 6;
  localparam int TIMEOUT_BIT = 5;

  // ----------------------------------------------------------------
  // Timing, 20 MHz system clock
  // ----------------------------------------------------------------
  localparam int CLK_NS              = 50;
  localparam int ACCESS_NS           = 90;
  localparam int WRITE_PULSE_NS      = 50;
  localparam int MIN_CLEAR_PULSE_NS  = 500;
  localparam int CLEAR_TO_READ_NS    = 50;
  localparam int ACCESS_CYC     = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_CYC      = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CLEAR_CYC      = (MIN_CLEAR_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RELEASE_CYC    = (CLEAR_TO_READ_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] POLL_MAX_RESET = 16'hffff;

endpackage : flash_host_pkg

// ==== flash_host_test.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Self-checking bench for the flash host
// ----------------------------------------------------------------
module flash_host_test;
  import flash_host_pkg::*;
  localparam logic [15:0] MFR = 16'h00a7; // Arbitrary value.
  localparam logic [15:0] DEV = 16'h3c5e; // Arbitrary value.
  logic        sys_clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, fail_mode = 0;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, rd_val;
  logic        cs_n, oe_n, we_n, clr_n, host_oe_n, rb_n;
  logic [18:0] fa;
  logic [15:0] host_d, dev_d;
  logic [127:0] erased = 0;
  logic        all_erased = 0;
  int          n_fail = 0, check_count = 0;
  integer      seed = 52;
  wire logic [15:0] bus = host_oe_n ? dev_d : host_d;

  flash_host uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .chip_select_n_o(cs_n), .output_enable_n_o(oe_n),
    .write_enable_n_o(we_n), .hard_clear_n_o(clr_n), .flash_addr_o(fa),
    .flash_data_i(bus), .flash_data_o(host_d), .flash_data_oe_n_o(host_oe_n),
    .ready_busy_n_i(rb_n));
  flash_dev_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) dev (.chip_select_n_i(cs_n),
    .output_enable_n_i(oe_n), .write_enable_n_i(we_n), .hard_clear_n_i(clr_n),
    .addr_i(fa), .data_i(bus), .data_o(dev_d), .ready_busy_n_o(rb_n), .fail_i(fail_mode));

  initial forever #25 sys_clk_i = !sys_clk_i;

  function automatic logic [15:0] model_word(input logic [18:0] a);
    int ix;
    ix = {a[18:12], a[2:0]};
    if (all_erased || erased[a[18:12]]) return 16'hffff;
    return 16'(ix * 16'h9e37) ^ 16'h5a5a;
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] want);
    check_count++;
    if (got !== want) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    d = reg_rdata_o;
  endtask

  task automatic op(input logic [2:0] c, input logic [18:0] a);
    int k;
    wr(REG_ADDR, {13'h0, a});
    wr(REG_CMD, {29'h0, c});
    k = 0;
    do begin
      rd(REG_STATUS, rd_val);
      k++;
    end while (rd_val[ST_BUSY] !== 1'b0 && k < 2000);
    check({15'h0, rd_val[ST_BUSY]}, 16'h0000);
  endtask

  task automatic rd_array(input logic [18:0] a);
    op(OP_READ, a);
    rd(REG_RDATA, rd_val);
    check(rd_val[15:0], model_word(a));
  endtask

  task automatic raw(input logic [18:0] a, input logic [15:0] d);
    wr(REG_WDATA, {16'h0, d});
    op(OP_WRITE, a);
  endtask

  task automatic stop_test();
    if (n_fail == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    n_fail++;
    $display("MISMATCH at %0t: run did not finish", $time);
    stop_test();
  end

  initial begin : main
    logic [6:0] s;
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd(REG_POLL_MAX, rd_val);
    check(rd_val[15:0], POLL_MAX_RESET);
    @(negedge sys_clk_i);
    check(reg_rdata_o[15:0], 16'h0000);
    wr(4'hf, 32'($random(seed)));
    rd(4'hf, rd_val);
    check(rd_val[15:0], 16'h0000);
    repeat (5) rd_array(19'($random(seed)));
    op(OP_READ_ID, 19'h0);
    rd(REG_RDATA, rd_val);
    check(rd_val[15:0], MFR);
    op(OP_READ, ADDR_DEV_ID);
    rd(REG_RDATA, rd_val);
    check(rd_val[15:0], DEV);
    op(OP_RESET_CMD, 19'h0);
    rd_array(19'h1);
    raw(19'h7f555, 16'h00aa);
    raw(19'h002aa, 16'h0077);
    raw(19'h00555, 16'h0090);
    rd_array(19'h0);
    raw(19'h7f555, 16'h00aa);
    raw(19'h402aa, 16'h0055);
    raw(19'h00555, 16'h0090);
    op(OP_READ, 19'h0);
    rd(REG_RDATA, rd_val);
    check(rd_val[15:0], MFR);
    op(OP_HARD_CLEAR, 19'h0);
    rd_array(19'h0);
    wr(REG_POLL_MAX, 32'h2);
    op(OP_SECT_ERASE, 19'h11000);
    rd(REG_STATUS, rd_val);
    check({11'h0, rd_val[4:0]}, 16'h0014);
    op(OP_HARD_CLEAR, 19'h0);
    rd(REG_STATUS, rd_val);
    check({11'h0, rd_val[4:0]}, 16'h000a);
    rd_array(19'h11002);
    wr(REG_POLL_MAX, {16'h0, POLL_MAX_RESET});
    op(OP_SECT_ERASE, 19'h11000);
    erased[7'h11] = 1'b1;
    rd_array(19'h11002);
    for (int j = 0; j < 2; j++) begin
      s = j ? 7'h7f : 7'($random(seed));
      op(OP_SECT_ERASE, {s, 12'h000});
      rd(REG_STATUS, rd_val);
      check({11'h0, rd_val[4:0]}, 16'h000a);
      erased[s] = 1'b1;
      rd_array({s, 12'h005});
      rd_array({s - 7'h01, 12'h003});
    end
    fail_mode <= 1'b1;
    op(OP_SECT_ERASE, 19'h23000);
    rd(REG_STATUS, rd_val);
    check({15'h0, rd_val[ST_FAIL]}, 16'h0001);
    fail_mode <= 1'b0;
    op(OP_RESET_CMD, 19'h0);
    rd_array(19'h23004);
    op(OP_CHIP_ERASE, 19'h0);
    all_erased = 1'b1;
    rd(REG_STATUS, rd_val);
    check({15'h0, rd_val[ST_DONE]}, 16'h0001);
    repeat (4) rd_array(19'($random(seed)));
    stop_test();
  end
endmodule // flash_host_test

`default_nettype wire
